/* hdl/vit_irq_ctrl.sv */
// Purpose: Vectored interrupt controller with free-running timer and GPIO edge logic.
// Assumes: AHB-Lite slave on clk, one word per register; CPU core handshakes vectors.
// Notes: Zero wait states; the CPU core moves the stacked bytes, this block sequences them.
//
// Function
// - Seven maskable sources, each delivered as vector.
// - Sources: reset, two taps, EP0, EP1, wake, GPIO.
// - Twelve-bit counter advancing every microsecond, wrapping.
// - Enabled taps interrupt every 128 us, 1.024 ms.
// - Each endpoint interrupts after its transaction completes.
// - Per-pin GPIO mask gates shared port request.
// - Per-pin rising or falling edge selection.
// - Counter value readable by firmware anytime.
// - Interrupt on start of alternate two-wire activity.
// - Acknowledge disables, pushes two bytes; return restores.
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`include "vit_map.svh"

module vit_irq_ctrl (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,

   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,

   // Event inputs from on-chip logic.
   input wire logic usbBusReset,
   input wire logic ep0Done,
   input wire logic ep1Done,
   input wire logic wakeTimer,

   // Pins.
   input wire logic [7:0] gpioPortZeroPins,
   input wire logic [1:0] gpioPortOnePins,
   input wire logic altSerialDataLine,

   // CPU core handshake.
   input wire logic irqAck,
   input wire logic returnFromInterruptInstr,
   output logic irqReq,
   output logic [2:0] irqVector,
   output logic stackWrite,
   output logic stackRead,
   output logic stackByteSel,

   // Level interrupt.
   output logic irq
);

   // ****************************************************************
   // State of the controller.
   // ****************************************************************
   typedef struct packed {
      logic [6:0] status;         // Sticky event bits, write one to clear.
      logic [6:0] mask;           // Per-source enables.

      logic globalEn;             // Global gate on vectored requests.
      logic altMode;              // Alternate two-wire mode on the data lines.

      logic [9:0] gpioEn;         // Per-pin GPIO enables.
      logic [9:0] gpioPol;        // Per-pin edge, high for rising.

      logic wrPend;               // A write data phase is due.
      logic [7:0] wrAddr;         // Byte address of the pending write.
      logic [31:0] rdata;         // Read data for the data phase.
      logic ready;                // Bus ready, high once out of reset.

      logic irq;                  // Level interrupt.
      logic req;                  // Vectored request to the core.
      logic [2:0] vec;            // Vector on offer.

      vit_pkg::vit_seq_type seq;  // Acknowledge and return sequence.
      logic stackWr;              // Strobe: core writes one stack byte.
      logic stackRd;              // Strobe: core reads one stack byte.
      logic stackByte;            // Which stack byte, low for the first.
   } vit_ctrl_type;

   vit_ctrl_type r_q;
   vit_ctrl_type r_d;

   // Timer and edge detector outputs.
   logic [11:0] timerCount;
   logic tapFast;
   logic tapSlow;
   logic gpioEvent;
   logic altEvent;

   // Combinational helpers.
   logic [6:0] setBits;
   logic [6:0] clrBits;
   logic [6:0] pending;
   logic addrTaken;
   logic ackTaken;

   // Lowest set bit wins; source 0 has the highest priority.
   function automatic logic [2:0] vit_lowest(input logic [6:0] bits);
      logic [2:0] idx;

      idx = 3'h0;
      for (int i = `VIT_NUM_SRC - 1; i >= 0; i--) begin
         if (bits[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction

   // ****************************************************************
   // Sub-blocks.
   // ****************************************************************

   // Microsecond counter and its two taps.
   vit_free_timer u_timer (
      .clk(clk),
      .resetn(resetn),
      .count(timerCount),
      .tapFast(tapFast),
      .tapSlow(tapSlow)
   );

   // GPIO edge detection over both ports.
   vit_edge_detect #(.WIDTH(`VIT_NUM_GPIO)) u_gpio (
      .clk(clk),
      .resetn(resetn),
      .pins({gpioPortOnePins, gpioPortZeroPins}),
      .pinEnable(r_q.gpioEn),
      .risingSel(r_q.gpioPol),
      .edgeEvent(gpioEvent)
   );

   // Start of two-wire activity is taken as any falling edge of the data line.
   vit_edge_detect #(.WIDTH(1)) u_alt (
      .clk(clk),
      .resetn(resetn),
      .pins(altSerialDataLine),
      .pinEnable(r_q.altMode),
      .risingSel(1'b0),
      .edgeEvent(altEvent)
   );

   // ****************************************************************
   // Next-state logic.
   // ****************************************************************

   // Bus slave, event capture, priority and the acknowledge sequence.
   always_comb begin
      r_d = r_q;
      r_d.ready = 1'b1;
      r_d.stackWr = 1'b0;
      r_d.stackRd = 1'b0;
      clrBits = `VIT_RST_SRC;

      // Address phase: only NONSEQ or SEQ with the bus ready are taken.
      addrTaken = hsel & htrans[1] & hready;
      r_d.wrPend = addrTaken & hwrite;
      r_d.wrAddr = haddr[7:0];
      r_d.rdata = 32'h0000_0000;

      if (addrTaken & ~hwrite) begin
         case (haddr[7:0])
            `VIT_ADDR_STATUS: r_d.rdata = {25'h0000000, r_q.status};
            `VIT_ADDR_MASK: r_d.rdata = {25'h0000000, r_q.mask};
            `VIT_ADDR_CONTROL: r_d.rdata = {30'h00000000, r_q.altMode, r_q.globalEn};
            `VIT_ADDR_GPIO_EN: r_d.rdata = {22'h000000, r_q.gpioEn};
            `VIT_ADDR_GPIO_POL: r_d.rdata = {22'h000000, r_q.gpioPol};
            `VIT_ADDR_TIMER: r_d.rdata = {20'h00000, timerCount};
            `VIT_ADDR_VECTOR: r_d.rdata = {28'h0000000, r_q.req, r_q.vec};
            // Unmapped addresses read as zero.
            default: r_d.rdata = 32'h0000_0000;
         endcase
      end

      // Each source sets its own sticky bit.
      setBits = `VIT_RST_SRC;
      setBits[`VIT_SRC_BUS_RESET] = usbBusReset | altEvent;
      setBits[`VIT_SRC_TAP_FAST] = tapFast;
      setBits[`VIT_SRC_TAP_SLOW] = tapSlow;
      setBits[`VIT_SRC_EP0] = ep0Done;
      setBits[`VIT_SRC_EP1] = ep1Done;
      setBits[`VIT_SRC_WAKE] = wakeTimer;
      setBits[`VIT_SRC_GPIO] = gpioEvent;

      // Acknowledge takes the vector on offer only while idle.
      ackTaken = irqAck & r_q.req & (r_q.seq == vit_pkg::VIT_SEQ_IDLE);

      // Sequence of two stack bytes on acknowledge and on return.
      case (r_q.seq)
         vit_pkg::VIT_SEQ_IDLE: begin
            // An acknowledge beats a return.
            if (ackTaken) begin
               clrBits[r_q.vec] = 1'b1;
               r_d.globalEn = 1'b0;
               r_d.seq = vit_pkg::VIT_SEQ_PUSH_FIRST;
               r_d.stackWr = 1'b1;
               r_d.stackByte = 1'b0;
            end else if (returnFromInterruptInstr) begin
               r_d.seq = vit_pkg::VIT_SEQ_POP_SECOND;
               r_d.stackRd = 1'b1;
               r_d.stackByte = 1'b1;
            end
         end

         vit_pkg::VIT_SEQ_PUSH_FIRST: begin
            r_d.seq = vit_pkg::VIT_SEQ_PUSH_SECOND;
            r_d.stackWr = 1'b1;
            r_d.stackByte = 1'b1;
         end

         vit_pkg::VIT_SEQ_PUSH_SECOND: begin
            r_d.seq = vit_pkg::VIT_SEQ_IDLE;
            r_d.stackByte = 1'b0;
         end

         vit_pkg::VIT_SEQ_POP_SECOND: begin
            r_d.seq = vit_pkg::VIT_SEQ_POP_FIRST;
            r_d.stackRd = 1'b1;
            r_d.stackByte = 1'b0;
         end

         vit_pkg::VIT_SEQ_POP_FIRST: begin
            // Interrupts come back only after both bytes are restored.
            r_d.seq = vit_pkg::VIT_SEQ_IDLE;
            r_d.globalEn = 1'b1;
         end

         // Unused codes fall back to idle.
         default: begin
            r_d.seq = vit_pkg::VIT_SEQ_IDLE;
         end
      endcase

      // Data phase of a write; a bus write to control overrides the sequence.
      if (r_q.wrPend) begin
         case (r_q.wrAddr)
            `VIT_ADDR_STATUS: clrBits = clrBits | hwdata[6:0];
            `VIT_ADDR_MASK: r_d.mask = hwdata[6:0];
            `VIT_ADDR_CONTROL: begin
               r_d.globalEn = hwdata[`VIT_CTRL_GLOBAL_EN];
               r_d.altMode = hwdata[`VIT_CTRL_ALT_MODE];
            end
            `VIT_ADDR_GPIO_EN: r_d.gpioEn = hwdata[9:0];
            `VIT_ADDR_GPIO_POL: r_d.gpioPol = hwdata[9:0];
            // Read-only and unmapped words ignore writes.
            default: r_d.gpioEn = r_q.gpioEn;
         endcase
      end

      // A new event beats a clear in the same cycle, so no event is lost.
      r_d.status = (r_q.status & ~clrBits) | setBits;

      // Level interrupt from unmasked sticky bits.
      pending = r_q.status & r_q.mask & ~clrBits;
      r_d.irq = |(r_q.status & r_q.mask);

      // Vectored request, gated globally and held off during a sequence.
      r_d.req = r_q.globalEn & r_d.globalEn & (|pending) & (r_d.seq == vit_pkg::VIT_SEQ_IDLE);
      r_d.vec = vit_lowest(pending);
   end

   // ****************************************************************
   // State register.
   // ****************************************************************

   // Everything resets to a known value; the global enable comes up cleared.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         r_q <= '0;
         r_q.seq <= vit_pkg::VIT_SEQ_IDLE;
      end else begin
         r_q <= r_d;
      end
   end

   // ****************************************************************
   // Outputs, each straight from the state register except hresp, tied low.
   // ****************************************************************
   assign hrdata = r_q.rdata;
   assign hreadyout = r_q.ready;
   // Every transfer ends OKAY.
   assign hresp = 1'b0;

   assign irqReq = r_q.req;
   assign irqVector = r_q.vec;
   assign stackWrite = r_q.stackWr;
   assign stackRead = r_q.stackRd;
   assign stackByteSel = r_q.stackByte;

   assign irq = r_q.irq;

endmodule

/* pkg/vit_map.svh */
// Purpose: Address map, field positions, reset values and timing counts of the interrupt controller.
// Assumes: Included by bare name; definitions only.
// Notes: Byte addresses on a 32-bit AHB-Lite bus, one aligned word per register.
`ifndef VIT_MAP_SVH
`define VIT_MAP_SVH

// ****************************************************************
// Register byte addresses.
// ****************************************************************
`define VIT_ADDR_STATUS 8'h00
`define VIT_ADDR_MASK 8'h04
`define VIT_ADDR_CONTROL 8'h08
`define VIT_ADDR_GPIO_EN 8'h0C
`define VIT_ADDR_GPIO_POL 8'h10
`define VIT_ADDR_TIMER 8'h14
`define VIT_ADDR_VECTOR 8'h18

// ****************************************************************
// Field positions and widths.
// ****************************************************************
`define VIT_NUM_SRC 7
`define VIT_NUM_GPIO 10
`define VIT_CTRL_GLOBAL_EN 0
`define VIT_CTRL_ALT_MODE 1
`define VIT_VEC_VALID 3
`define VIT_SRC_BUS_RESET 0
`define VIT_SRC_TAP_FAST 1
`define VIT_SRC_TAP_SLOW 2
`define VIT_SRC_EP0 3
`define VIT_SRC_EP1 4
`define VIT_SRC_WAKE 5
`define VIT_SRC_GPIO 6

// ****************************************************************
// Reset values.
// ****************************************************************
`define VIT_RST_SRC 7'h00
`define VIT_RST_GPIO 10'h000
`define VIT_RST_TIMER 12'h000
`define VIT_RST_DIV 8'h00

// ****************************************************************
// Timing: one timer tick per microsecond from a 5 ns clock.
// ****************************************************************
`define VIT_CLK_PERIOD_NS 5
`define VIT_TICK_PERIOD_NS 1000
`define VIT_TICK_CYCLES (`VIT_TICK_PERIOD_NS / `VIT_CLK_PERIOD_NS)
`define VIT_TAP_FAST_US 128
`define VIT_TAP_SLOW_US 1024
`define VIT_TAP_FAST_MASK 12'h07F
`define VIT_TAP_SLOW_MASK 12'h3FF

`endif

/* pkg/vit_pkg.sv */
// Purpose: Types shared by the interrupt controller files.
// Assumes: Nothing is imported; users write vit_pkg::name.
// Notes: Offsets and counts live in vit_map.svh.
package vit_pkg;

   // ****************************************************************
   // Acknowledge and return sequence of the vector unit.
   // ****************************************************************
   typedef enum logic [2:0] {
      VIT_SEQ_IDLE,
      VIT_SEQ_PUSH_FIRST,
      VIT_SEQ_PUSH_SECOND,
      VIT_SEQ_POP_SECOND,
      VIT_SEQ_POP_FIRST
   } vit_seq_type;

endpackage

/* hdl/vit_free_timer.sv */
// Purpose: Free-running 12-bit microsecond counter with two periodic taps.
// Assumes: Single 200 MHz clock, synchronous active-low reset.
// Notes: Tap pulses last one clock cycle, at the tick that wraps the tap field.
`timescale 1ns/100ps
`include "vit_map.svh"

module vit_free_timer (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Counter value and tap pulses.
   output logic [11:0] count,
   output logic tapFast,
   output logic tapSlow
);

   // ****************************************************************
   // State of the timer.
   // ****************************************************************
   typedef struct packed {
      logic [7:0] div;     // Clock cycles within the current microsecond.
      logic [11:0] count;  // Microsecond count, wraps by itself.
      logic tapFast;       // One-cycle pulse every 128 us.
      logic tapSlow;       // One-cycle pulse every 1.024 ms.
   } vit_timer_type;

   vit_timer_type r_q;
   vit_timer_type r_d;

   // Divider and counter; taps fire when the tap field is about to wrap.
   always_comb begin
      r_d = r_q;
      r_d.tapFast = 1'b0;
      r_d.tapSlow = 1'b0;
      if (r_q.div == 8'(`VIT_TICK_CYCLES - 1)) begin
         r_d.div = `VIT_RST_DIV;
         r_d.count = r_q.count + 12'h001;
         r_d.tapFast = ((r_q.count & `VIT_TAP_FAST_MASK) == `VIT_TAP_FAST_MASK);
         r_d.tapSlow = ((r_q.count & `VIT_TAP_SLOW_MASK) == `VIT_TAP_SLOW_MASK);
      end else begin
         r_d.div = r_q.div + 8'h01;
      end
   end

   // Register the timer state.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign count = r_q.count;
   assign tapFast = r_q.tapFast;
   assign tapSlow = r_q.tapSlow;

endmodule

/* hdl/vit_edge_detect.sv */
// Purpose: Synchronises pins and raises one pulse on a selected edge of an enabled pin.
// Assumes: Pins are asynchronous to clk.
// Notes: Polarity bit high selects rising edge, low selects falling edge.
`timescale 1ns/100ps

module vit_edge_detect #(
   parameter int WIDTH = 10
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Pins and per-pin controls.
   input wire logic [WIDTH-1:0] pins,
   input wire logic [WIDTH-1:0] pinEnable,
   input wire logic [WIDTH-1:0] risingSel,
   // Combined edge pulse.
   output logic edgeEvent
);

   // ****************************************************************
   // State of the detector.
   // ****************************************************************
   typedef struct packed {
      logic [WIDTH-1:0] meta;  // First synchroniser stage, read only by the second.
      logic [WIDTH-1:0] sync;  // Second synchroniser stage.
      logic [WIDTH-1:0] prev;  // Previous synchronised level.
      logic edgeEvent;         // One-cycle pulse on a qualifying edge.
   } vit_edge_type;

   vit_edge_type r_q;
   vit_edge_type r_d;
   logic [WIDTH-1:0] rise;
   logic [WIDTH-1:0] fall;

   // Edge selection per pin, masked per pin, then ORed into one request.
   always_comb begin
      r_d = r_q;
      r_d.meta = pins;
      r_d.sync = r_q.meta;
      r_d.prev = r_q.sync;
      rise = r_q.sync & ~r_q.prev;
      fall = ~r_q.sync & r_q.prev;
      r_d.edgeEvent = |(((risingSel & rise) | (~risingSel & fall)) & pinEnable);
   end

   // Register; the zeroed stages may show one false rising edge after reset, which
   // the enables, also reset low, keep out: no bus write can land that early.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign edgeEvent = r_q.edgeEvent;

endmodule

/* tb/vit_cpu_model.sv */
// Purpose: Behavioural CPU core that takes vectors from the controller.
// Assumes: One clock; requests change just after a rising edge.
// Notes: slowMode stretches the handler so pending requests pile up.
`timescale 1ns/100ps
module vit_cpu_model (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Controller side.
   input wire logic irqReq,
   input wire logic [2:0] irqVector,
   output logic irqAck,
   output logic returnFromInterruptInstr,
   // Bench side.
   input wire logic slowMode,
   output logic [2:0] lastVec,
   output logic [7:0] nServed
);
   // Quiet at time zero so no stray acknowledge is seen in reset.
   initial begin
      irqAck = 1'b0;
      returnFromInterruptInstr = 1'b0;
      lastVec = 3'h0;
      nServed = 8'h00;
   end
   // One acknowledge per offered vector, then a return after the pushes.
   always begin
      @(posedge clk);
      if (resetn === 1'b1 && irqReq === 1'b1) begin
         irqAck <= 1'b1;
         lastVec <= irqVector;
         @(posedge clk);
         irqAck <= 1'b0;
         // Let both stacked bytes pass before the return is issued.
         repeat (3) @(posedge clk);
         repeat (slowMode ? 40 : 0) @(posedge clk);
         returnFromInterruptInstr <= 1'b1;
         @(posedge clk);
         returnFromInterruptInstr <= 1'b0;
         // The enable comes back only after both pops.
         repeat (3) @(posedge clk);
         nServed <= nServed + 8'h01;
      end
   end
endmodule

/* tb/vit_irq_ctrl_properties.sv */
// Purpose: Port checks of the interrupt controller.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Registers are hidden, so the bus decode is shadowed here.
`timescale 1ns/100ps
module vit_irq_ctrl_properties (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Bus.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   // Core handshake.
   input wire logic irqAck,
   input wire logic returnFromInterruptInstr,
   input wire logic irqReq,
   input wire logic [2:0] irqVector,
   input wire logic stackWrite,
   input wire logic stackRead,
   input wire logic stackByteSel
);
   // ********
   // Shadow of the bus decode.
   // ********
   logic take; // Address phase accepted at this edge.
   logic rdPhase_q; // A read data phase is running.
   logic [7:0] rdAddr_q; // Byte address of that read.
   logic ctlWr_q; // Control written since reset.
   assign take = hsel && htrans[1] && hready;
   // A reset forgets any write of control, as the enable is cleared too.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdPhase_q <= 1'b0;
         rdAddr_q <= 8'h00;
         ctlWr_q <= 1'b0;
      end else begin
         rdPhase_q <= take && !hwrite;
         rdAddr_q <= haddr[7:0];
         ctlWr_q <= ctlWr_q || (take && hwrite && haddr[7:0] == 8'h08);
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // ********
   // Assertions.
   // ********
   a_ready_up: assert property ($past(resetn) |-> hreadyout)
      else $error("bus not ready after reset");
   a_rd_idle: assert property (!rdPhase_q |-> hrdata == 32'h0)
      else $error("read data outside a read");
   a_timer_width: assert property (rdPhase_q && rdAddr_q == 8'h14 |-> hrdata[31:12] == 20'h0)
      else $error("timer wider than twelve bits");
   a_status_width: assert property (rdPhase_q && rdAddr_q == 8'h00 |-> hrdata[31:7] == 25'h0)
      else $error("status wider than seven sources");
   a_enable_reset: assert property (!ctlWr_q |-> !irqReq)
      else $error("request before global enable");
   a_vec_range: assert property (irqReq |-> irqVector <= 3'h6)
      else $error("vector out of range");
   a_ack_push: assert property (irqAck && irqReq |=> stackWrite && !stackByteSel
      ##1 stackWrite && stackByteSel ##1 !stackWrite) else $error("push order wrong");
   a_return_from_interrupt_instr_pop: assert property (returnFromInterruptInstr && !irqReq && !stackWrite && !stackRead
      |=> stackRead && stackByteSel ##1 stackRead && !stackByteSel ##1 !stackRead) else $error("pop order wrong");
   a_one_vector: assert property (irqAck && irqReq |=> !irqReq [*3])
      else $error("second vector during acknowledge");
   a_strobe_excl: assert property (!(stackWrite && stackRead))
      else $error("push and pop together");
   c_ack: cover property (irqAck && irqReq ##1 stackWrite);
   c_return_from_interrupt_instr: cover property (returnFromInterruptInstr ##1 stackRead);
   c_timer: cover property (rdPhase_q && rdAddr_q == 8'h14);
endmodule
bind vit_irq_ctrl vit_irq_ctrl_properties chk (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .irqAck(irqAck), .returnFromInterruptInstr(returnFromInterruptInstr), .irqReq(irqReq),
   .irqVector(irqVector), .stackWrite(stackWrite), .stackRead(stackRead), .stackByteSel(stackByteSel));

/* tb/vit_irq_ctrl_test.sv */
// Purpose: Self-checking bench of the interrupt controller.
// Assumes: 200 MHz clock; zero-wait bus slave drives hready itself.
// Notes: Rows give event kind and expected vector; odd cases follow.
`timescale 1ns/100ps
`include "vit_map.svh"
module vit_irq_ctrl_test;
   logic clk, resetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, r1, r2;
   logic [1:0] htrans, gpioPortOnePins;
   logic [2:0] hsize, irqVector, lastVec;
   logic usbBusReset, ep0Done, ep1Done, wakeTimer, altSerialDataLine;
   logic [7:0] gpioPortZeroPins, nServed;
   logic irqAck, ret, irqReq, stackWrite, stackRead, stackByteSel, irq, slowMode;
   logic [5:0] rows [7]; // Kind in bits 5:3, vector in bits 2:0.
   int errTotal, nChecks, i;
   assign hready = hreadyout; // The one slave drives the bus ready.
   vit_irq_ctrl dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .usbBusReset(usbBusReset), .ep0Done(ep0Done),
      .ep1Done(ep1Done), .wakeTimer(wakeTimer), .gpioPortZeroPins(gpioPortZeroPins),
      .gpioPortOnePins(gpioPortOnePins), .altSerialDataLine(altSerialDataLine), .irqAck(irqAck),
      .returnFromInterruptInstr(ret), .irqReq(irqReq), .irqVector(irqVector),
      .stackWrite(stackWrite), .stackRead(stackRead), .stackByteSel(stackByteSel), .irq(irq));
   vit_cpu_model cpu (.clk(clk), .resetn(resetn), .irqReq(irqReq), .irqVector(irqVector),
      .irqAck(irqAck), .returnFromInterruptInstr(ret), .slowMode(slowMode), .lastVec(lastVec),
      .nServed(nServed));
   // Verdict and end of run, reached from the main flow and every timeout.
   task endSim;
      if (errTotal == 0 && nChecks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task check(input string what, input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp) begin
         errTotal++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Waits for ready at an edge; a dead bus ends the run.
   task hwait;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         check("bus ready", 32'h0, 32'h1);
         endSim();
      end
   endtask
   // One single word transfer: address phase, then data phase.
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h000000, a};
      hwait();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      hwait();
      r = hrdata;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      check(what, r, exp);
   endtask
   // Raises one event; pins keep their new level.
   task fire(input logic [2:0] k);
      case (k)
         3'h0: usbBusReset <= 1'b1;
         3'h1: ep0Done <= 1'b1;
         3'h2: ep1Done <= 1'b1;
         3'h3: wakeTimer <= 1'b1;
         3'h4: gpioPortZeroPins[3] <= 1'b1;
         3'h5: gpioPortOnePins[1] <= 1'b0;
         default: altSerialDataLine <= 1'b0;
      endcase
      @(posedge clk);
      {usbBusReset, ep0Done, ep1Done, wakeTimer} <= 4'h0;
      @(posedge clk);
   endtask
   // Waits for the core to finish one handler and checks its vector.
   task served(input logic [2:0] exp);
      logic [7:0] old;
      int n;
      old = nServed;
      n = 0;
      while (nServed === old && n < 400) begin
         @(posedge clk);
         n++;
      end
      if (n >= 400) begin
         check("served", 32'h0, 32'h1);
         endSim();
      end
      check("vector", {29'h0, lastVec}, {29'h0, exp});
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Hang guard.
   initial begin
      repeat (100000) @(posedge clk);
      check("timeout", 32'h0, 32'h1);
      endSim();
   end
   initial begin
      {resetn, hsel, hwrite, usbBusReset, ep0Done, ep1Done, wakeTimer, slowMode} = 8'h00;
      {haddr, hwdata, htrans, gpioPortZeroPins} = 74'h0;
      hsize = 3'h2;
      gpioPortOnePins = 2'h3;
      altSerialDataLine = 1'b1;
      errTotal = 0;
      nChecks = 0;
      rows = '{6'h00, 6'h0B, 6'h14, 6'h1D, 6'h26, 6'h2E, 6'h30};
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      for (i = 0; i < 8; i++) begin
         rdc("reset value", (i == 7) ? 8'h40 : 8'(i * 4), 32'h0);
      end
      wr(`VIT_ADDR_GPIO_EN, 32'h208);
      wr(`VIT_ADDR_GPIO_POL, 32'h008);
      wr(`VIT_ADDR_MASK, 32'h79);
      wr(`VIT_ADDR_CONTROL, 32'h3);
      for (i = 0; i < 7; i++) begin
         fire(rows[i][5:3]);
         served(rows[i][2:0]);
         rdc("status after ack", `VIT_ADDR_STATUS, 32'h0);
      end
      // Two pending at once, handled in priority order by a slow core.
      slowMode <= 1'b1;
      wr(`VIT_ADDR_CONTROL, 32'h2);
      {usbBusReset, ep1Done} <= 2'h3;
      @(posedge clk);
      {usbBusReset, ep1Done} <= 2'h0;
      @(posedge clk);
      rdc("pending", `VIT_ADDR_STATUS, 32'h11);
      wr(`VIT_ADDR_CONTROL, 32'h3);
      served(3'h0);
      served(3'h4);
      // Level output follows mask and clear; no vector while disabled.
      wr(`VIT_ADDR_CONTROL, 32'h2);
      wr(`VIT_ADDR_MASK, 32'h0);
      fire(3'h1);
      rdc("status set", `VIT_ADDR_STATUS, 32'h08);
      check("irq masked", {31'h0, irq}, 32'h0);
      wr(`VIT_ADDR_MASK, 32'h08);
      repeat (2) @(posedge clk);
      check("irq raised", {31'h0, irq}, 32'h1);
      check("no request", {31'h0, irqReq}, 32'h0);
      wr(`VIT_ADDR_STATUS, 32'h08);
      repeat (2) @(posedge clk);
      check("irq cleared", {31'h0, irq}, 32'h0);
      // Wrong-direction edges and a disabled pin must stay silent.
      gpioPortZeroPins[3] <= 1'b0;
      gpioPortZeroPins[5] <= 1'b1;
      gpioPortOnePins[1] <= 1'b1;
      altSerialDataLine <= 1'b1;
      repeat (10) @(posedge clk);
      rdc("quiet pins", `VIT_ADDR_STATUS, 32'h0);
      wr(8'h40, 32'hFFFFFFFF);
      rdc("unmapped", 8'h40, 32'h0);
      // Two timer reads 400 cycles apart differ by two ticks.
      bus(1'b0, `VIT_ADDR_TIMER, 32'h0, r1);
      repeat (398) @(posedge clk);
      bus(1'b0, `VIT_ADDR_TIMER, 32'h0, r2);
      check("timer step", {20'h0, 12'(r2[11:0] - r1[11:0])}, 32'h2);
      i = 0;
      do begin
         repeat (100) @(posedge clk);
         bus(1'b0, `VIT_ADDR_STATUS, 32'h0, r1);
         i++;
      end while (r1[1] !== 1'b1 && i < 400);
      check("fast tap", {30'h0, r1[2:1]}, 32'h1);
      endSim();
   end
endmodule
